// >>> include/fsp_pkg.sv
// shared constants and carrier types for the flash self-program sequencer
package fsp_pkg;

  // register map (byte offsets on the 8-bit register port)
  localparam logic [7:0] FSP_CTRL_OFS     = 8'h00;
  localparam logic [7:0] FSP_LOCK_OFS     = 8'h01;

  // spm_ctrl_status field positions
  localparam int         FSP_IE_BIT       = 7;
  localparam int         FSP_RWWB_BIT     = 6;
  localparam int         FSP_RWWRE_BIT    = 4;
  localparam int         FSP_LSET_BIT     = 3;
  localparam int         FSP_PWRT_BIT     = 2;
  localparam int         FSP_PERS_BIT     = 1;
  localparam int         FSP_SEN_BIT      = 0;

  // command patterns in the low five bits
  localparam logic [4:0] FSP_CMD_LOAD     = 5'h01;
  localparam logic [4:0] FSP_CMD_ERASE    = 5'h03;
  localparam logic [4:0] FSP_CMD_WRITE    = 5'h05;
  localparam logic [4:0] FSP_CMD_LOCK     = 5'h09;
  localparam logic [4:0] FSP_CMD_RWWRE    = 5'h11;

  // reset and erased values
  localparam logic [7:0]  FSP_CTRL_RESET  = 8'h00;
  localparam logic [7:0]  FSP_LOCK_RESET  = 8'hFF;
  localparam logic [15:0] FSP_ERASED_WORD = 16'hFFFF;
  localparam logic [7:0]  FSP_NO_DATA     = 8'hFF;
  localparam logic [5:0]  FSP_BOOT_LOCK_MASK = 6'h3C;

  // windows after a command write, in clock cycles
  localparam logic [2:0] FSP_STORE_WINDOW = 3'h4;
  localparam logic [2:0] FSP_LOAD_WINDOW  = 3'h3;

  // pointer values selecting the byte returned in a read window
  localparam logic [15:0] FSP_Z_FUSE_LOW  = 16'h0000;
  localparam logic [15:0] FSP_Z_LOCK      = 16'h0001;
  localparam logic [15:0] FSP_Z_FUSE_EXT  = 16'h0002;
  localparam logic [15:0] FSP_Z_FUSE_HIGH = 16'h0003;

  // cell programming time; least time, so the cycle count rounds up
  localparam int FSP_CLK_PERIOD_NS = 10;
  localparam int FSP_PROG_TIME_US  = 3700;
  localparam int FSP_PROG_CYCLES   =
    (FSP_PROG_TIME_US * 1000 + FSP_CLK_PERIOD_NS - 1) / FSP_CLK_PERIOD_NS;

  typedef enum logic [1:0] {FSP_IDLE, FSP_ARMED, FSP_BUSY} fsp_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } fsp_reg_req_s;

  typedef struct packed {
    logic        store;
    logic        load;
    logic [15:0] z;
    logic [7:0]  high_data_register;
    logic [7:0]  low_data_register;
  } fsp_cpu_req_s;

  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic [7:0] ext;
  } fsp_fuse_s;

endpackage : fsp_pkg

// >>> rtl/fsp_sequencer.sv
// flash self-program sequencer: command register, page buffer, timed operations
//
// Summary of operation
// - erase pattern plus store erases pointer page
// - erase page comes only from page_field
// - erase: other area readable, halt if own area
// - load pattern plus store puts word in buffer
// - buffer cleared after write, read-enable, reset
// - eeprom write during filling discards buffer
// - write pattern plus store programs buffer page
// - write: other area readable, halt if own
// - ready interrupt high while store_enable clear
// - erase/write blocks read_while_write_area, sets rww_busy
// - lock-set pattern plus store programs lock
// - lock bits 5..2 programmed where data zero
// - lock programming leaves flash fully readable
// - eeprom write blocks commands and fuse reads
// - lock-set plus load in three reads lock
// - windows expire: three for load, four store
// - pointer selects low, high, extended fuse
// - programmed bits read zero, unprogrammed one
// - undefined command patterns are ignored
// - store_enable stays set through erase/write
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ns

module fsp_sequencer
  import fsp_pkg::*;
#(
  parameter int PAGE_WORD_BITS  = 6,
  parameter int HALT_FIRST_PAGE = 480,
  parameter int PROG_CYCLES     = FSP_PROG_CYCLES
) (
  // clock and reset
  input  logic                      clk_in,
  input  logic                      rst_in,
  // register port
  input  fsp_reg_req_s              reg_req_in,
  output logic [7:0]                reg_rdata_out,
  // cpu store / load-program requests
  input  fsp_cpu_req_s              cpu_req_in,
  output logic [7:0]                lpm_data_out,
  output logic                      lpm_hit_out,
  output logic                      halt_out,
  output logic                      irq_out,
  // eeprom and fuses
  input  logic                      eeprom_write_busy_in,
  input  fsp_fuse_s                 fuse_in,
  // flash array side
  input  logic [PAGE_WORD_BITS-1:0] flash_buf_addr_in,
  output logic [15:0]               flash_buf_data_out,
  output logic                      flash_erase_out,
  output logic                      flash_write_out,
  output logic [14-PAGE_WORD_BITS:0] flash_page_out,
  output logic                      rww_busy_out,
  output logic [7:0]                lock_bits_out
);

  localparam int PAGE_WORDS = 1 << PAGE_WORD_BITS;
  localparam int PAGE_BITS  = 15 - PAGE_WORD_BITS;

  typedef struct packed {
    fsp_state_e                          st;
    logic                                ie;
    logic                                rww_busy;
    logic                                rww_re;
    logic                                lock_set;
    logic                                pg_wrt;
    logic                                pg_ers;
    logic                                spm_en;
    logic [2:0]                          win;
    logic [31:0]                         cnt;
    logic [PAGE_BITS-1:0]                page;
    logic                                filling;
    logic                                halt;
    logic                                irq;
    logic                                erase_p;
    logic                                write_p;
    logic                                lpm_hit;
    logic [7:0]                          lock;
    logic [7:0]                          rdata;
    logic [7:0]                          lpm_data;
    logic [15:0]                         bufd;
    logic [PAGE_WORDS-1:0][15:0]         pbuf;
  } fsp_state_s;

  fsp_state_s s_r;
  fsp_state_s s_nxt;

  logic [4:0]           cmd_w;
  logic [4:0]           wr_cmd_w;
  logic                 ctrl_wr_w;
  logic [PAGE_BITS-1:0] z_page_w;
  logic [PAGE_WORD_BITS-1:0] z_word_w;

  assign cmd_w     = {s_r.rww_re, s_r.lock_set, s_r.pg_wrt, s_r.pg_ers, s_r.spm_en};
  assign wr_cmd_w  = reg_req_in.wdata[4:0];
  assign ctrl_wr_w = reg_req_in.wr && (reg_req_in.addr == FSP_CTRL_OFS);
  assign z_page_w  = cpu_req_in.z[15:PAGE_WORD_BITS+1];
  assign z_word_w  = cpu_req_in.z[PAGE_WORD_BITS:1];

  function automatic logic cmd_valid(input logic [4:0] c);
    cmd_valid = (c == FSP_CMD_LOAD) || (c == FSP_CMD_ERASE) || (c == FSP_CMD_WRITE) ||
                (c == FSP_CMD_LOCK) || (c == FSP_CMD_RWWRE);
  endfunction : cmd_valid

  // fuse and lock bytes pass through as stored: 0 = programmed, 1 = not
  function automatic logic [7:0] read_sel(input logic [15:0] z, input logic [7:0] lock,
                                          input fsp_fuse_s f);
    case (z)
      FSP_Z_LOCK:      read_sel = lock;
      FSP_Z_FUSE_LOW:  read_sel = f.low;
      FSP_Z_FUSE_HIGH: read_sel = f.high;
      FSP_Z_FUSE_EXT:  read_sel = f.ext;
      default:         read_sel = FSP_NO_DATA;
    endcase
  endfunction : read_sel

  function automatic fsp_state_s end_cmd(input fsp_state_s x);
    fsp_state_s y;
    y          = x;
    y.rww_re   = 1'b0;
    y.lock_set = 1'b0;
    y.pg_wrt   = 1'b0;
    y.pg_ers   = 1'b0;
    y.spm_en   = 1'b0;
    y.win      = 3'h0;
    y.st       = FSP_IDLE;
    end_cmd    = y;
  endfunction : end_cmd

  function automatic fsp_state_s reset_state();
    fsp_state_s y;
    y          = '0;
    y.st       = FSP_IDLE;
    {y.ie, y.rww_busy, y.rww_re, y.lock_set, y.pg_wrt, y.pg_ers, y.spm_en} =
      {FSP_CTRL_RESET[7:6], FSP_CTRL_RESET[4:0]};
    y.lock     = FSP_LOCK_RESET;
    y.pbuf     = {PAGE_WORDS{FSP_ERASED_WORD}};
    reset_state = y;
  endfunction : reset_state

  always_comb begin
    s_nxt         = s_r;
    s_nxt.erase_p = 1'b0;
    s_nxt.write_p = 1'b0;
    s_nxt.lpm_hit = 1'b0;
    s_nxt.rdata   = 8'h00;
    s_nxt.bufd    = s_r.pbuf[flash_buf_addr_in];

    if (reg_req_in.rd) begin
      case (reg_req_in.addr)
        FSP_CTRL_OFS: s_nxt.rdata = {s_r.ie, s_r.rww_busy, 1'b0, cmd_w};
        FSP_LOCK_OFS: s_nxt.rdata = s_r.lock;
        default:      s_nxt.rdata = 8'h00;
      endcase
    end

    // an eeprom write mid-fill loses the partial page
    if (eeprom_write_busy_in && s_r.filling) begin
      s_nxt.pbuf    = {PAGE_WORDS{FSP_ERASED_WORD}};
      s_nxt.filling = 1'b0;
    end

    // the enable bit is always writable; command bits only from idle
    if (ctrl_wr_w) begin
      s_nxt.ie = reg_req_in.wdata[FSP_IE_BIT];
    end

    case (s_r.st)
      FSP_IDLE: begin
        if (ctrl_wr_w && !eeprom_write_busy_in && cmd_valid(wr_cmd_w)) begin
          s_nxt.rww_re   = reg_req_in.wdata[FSP_RWWRE_BIT];
          s_nxt.lock_set = reg_req_in.wdata[FSP_LSET_BIT];
          s_nxt.pg_wrt   = reg_req_in.wdata[FSP_PWRT_BIT];
          s_nxt.pg_ers   = reg_req_in.wdata[FSP_PERS_BIT];
          s_nxt.spm_en   = reg_req_in.wdata[FSP_SEN_BIT];
          s_nxt.win      = FSP_STORE_WINDOW;
          s_nxt.st       = FSP_ARMED;
          if (wr_cmd_w == FSP_CMD_RWWRE) begin
            s_nxt.pbuf    = {PAGE_WORDS{FSP_ERASED_WORD}};
            s_nxt.filling = 1'b0;
          end
        end
      end
      FSP_ARMED: begin
        if (cpu_req_in.store) begin
          s_nxt = end_cmd(s_nxt);
          if (!eeprom_write_busy_in) begin
            case (cmd_w)
              FSP_CMD_LOAD: begin
                s_nxt.pbuf[z_word_w] = {cpu_req_in.high_data_register,
                                        cpu_req_in.low_data_register};
                s_nxt.filling        = 1'b1;
                s_nxt.rww_busy       = 1'b0;
              end
              FSP_CMD_ERASE, FSP_CMD_WRITE: begin
                s_nxt.st       = FSP_BUSY;
                s_nxt.spm_en   = 1'b1;
                s_nxt.pg_ers   = s_r.pg_ers;
                s_nxt.pg_wrt   = s_r.pg_wrt;
                s_nxt.page     = z_page_w;
                s_nxt.erase_p  = s_r.pg_ers;
                s_nxt.write_p  = s_r.pg_wrt;
                s_nxt.rww_busy = 1'b1;
                s_nxt.halt     = (z_page_w >= PAGE_BITS'(HALT_FIRST_PAGE));
                s_nxt.cnt      = 32'(PROG_CYCLES);
              end
              FSP_CMD_LOCK: begin
                // only boot lock bits change, and only toward programmed
                s_nxt.lock[5:2] = s_r.lock[5:2] & cpu_req_in.low_data_register[5:2];
                s_nxt.st        = FSP_BUSY;
                s_nxt.spm_en    = 1'b1;
                s_nxt.lock_set  = 1'b1;
                s_nxt.halt      = 1'b0;
                s_nxt.cnt       = 32'(PROG_CYCLES);
              end
              FSP_CMD_RWWRE: begin
                s_nxt.rww_busy = 1'b0;
              end
              default: begin
                s_nxt.rww_busy = s_r.rww_busy;
              end
            endcase
          end
        end else if (cpu_req_in.load && s_r.lock_set && !s_r.pg_wrt && !s_r.pg_ers &&
                     (s_r.win > (FSP_STORE_WINDOW - FSP_LOAD_WINDOW))) begin
          s_nxt = end_cmd(s_nxt);
          if (!eeprom_write_busy_in) begin
            s_nxt.lpm_data = read_sel(cpu_req_in.z, s_r.lock, fuse_in);
            s_nxt.lpm_hit  = 1'b1;
          end
        end else if (s_r.win == 3'h1) begin
          s_nxt = end_cmd(s_nxt);
        end else begin
          s_nxt.win = s_r.win - 3'h1;
        end
      end
      FSP_BUSY: begin
        if (s_r.cnt <= 32'h1) begin
          s_nxt      = end_cmd(s_nxt);
          s_nxt.halt = 1'b0;
          if (s_r.pg_wrt) begin
            s_nxt.pbuf    = {PAGE_WORDS{FSP_ERASED_WORD}};
            s_nxt.filling = 1'b0;
          end
        end else begin
          s_nxt.cnt = s_r.cnt - 32'h1;
        end
      end
      default: begin
        s_nxt = end_cmd(s_nxt);
      end
    endcase

    s_nxt.irq = s_nxt.ie && !s_nxt.spm_en;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_r <= reset_state();
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata_out      = s_r.rdata;
  assign lpm_data_out       = s_r.lpm_data;
  assign lpm_hit_out        = s_r.lpm_hit;
  assign halt_out           = s_r.halt;
  assign irq_out            = s_r.irq;
  assign flash_buf_data_out = s_r.bufd;
  assign flash_erase_out    = s_r.erase_p;
  assign flash_write_out    = s_r.write_p;
  assign flash_page_out     = s_r.page;
  assign rww_busy_out       = s_r.rww_busy;
  assign lock_bits_out      = s_r.lock;

  // checks

  property p_erase_start;
    @(posedge clk_in) disable iff (rst_in)
    (s_r.st == FSP_ARMED && cmd_w == FSP_CMD_ERASE && cpu_req_in.store &&
     !eeprom_write_busy_in)
    |=> (flash_erase_out && !flash_write_out && s_r.st == FSP_BUSY &&
         flash_page_out == $past(cpu_req_in.z[15:PAGE_WORD_BITS+1]));
  endproperty
  a_erase_start: assert property (p_erase_start)
    else $error("erase did not start on the pointer page");

  property p_write_start;
    @(posedge clk_in) disable iff (rst_in)
    (s_r.st == FSP_ARMED && cmd_w == FSP_CMD_WRITE && cpu_req_in.store &&
     !eeprom_write_busy_in)
    |=> (flash_write_out && rww_busy_out) ##1 !flash_write_out;
  endproperty
  a_write_start: assert property (p_write_start)
    else $error("page write strobe missing or not one cycle");

  property p_busy_blocks;
    @(posedge clk_in) disable iff (rst_in)
    (s_r.st == FSP_BUSY && (s_r.pg_wrt || s_r.pg_ers)) |-> (rww_busy_out && s_r.spm_en);
  endproperty
  a_busy_blocks: assert property (p_busy_blocks)
    else $error("read_while_write_area or store_enable released during erase/write");

  property p_halt_area;
    @(posedge clk_in) disable iff (rst_in)
    (s_r.st == FSP_BUSY && (s_r.pg_wrt || s_r.pg_ers))
    |-> (halt_out == (flash_page_out >= PAGE_BITS'(HALT_FIRST_PAGE)));
  endproperty
  a_halt_area: assert property (p_halt_area)
    else $error("halt does not follow the page area");

  property p_lock_no_halt;
    @(posedge clk_in) disable iff (rst_in)
    (s_r.st == FSP_BUSY && s_r.lock_set) |-> !halt_out;
  endproperty
  a_lock_no_halt: assert property (p_lock_no_halt)
    else $error("cpu halted during lock programming");

  property p_lock_prog;
    @(posedge clk_in) disable iff (rst_in)
    (s_r.st == FSP_ARMED && cmd_w == FSP_CMD_LOCK && cpu_req_in.store &&
     !eeprom_write_busy_in)
    |=> (lock_bits_out == ($past(lock_bits_out) &
         ($past(cpu_req_in.low_data_register) | ~{2'h0, FSP_BOOT_LOCK_MASK})));
  endproperty
  a_lock_prog: assert property (p_lock_prog)
    else $error("lock bits not programmed from data bits 5..2");

  property p_ee_blocks;
    @(posedge clk_in) disable iff (rst_in)
    (s_r.st == FSP_IDLE && ctrl_wr_w && eeprom_write_busy_in) |=> !s_r.spm_en;
  endproperty
  a_ee_blocks: assert property (p_ee_blocks)
    else $error("command accepted during eeprom write");

  property p_bad_cmd;
    @(posedge clk_in) disable iff (rst_in)
    (s_r.st == FSP_IDLE && ctrl_wr_w && !cmd_valid(wr_cmd_w)) |=> (cmd_w == 5'h00);
  endproperty
  a_bad_cmd: assert property (p_bad_cmd)
    else $error("undefined command pattern changed command bits");

  property p_win_expire;
    @(posedge clk_in) disable iff (rst_in)
    (s_r.st == FSP_ARMED && s_r.win == FSP_STORE_WINDOW &&
     !cpu_req_in.store && !cpu_req_in.load)
    ##1 (!cpu_req_in.store && !cpu_req_in.load)[*3]
    |=> (!s_r.spm_en && !s_r.lock_set && s_r.st == FSP_IDLE);
  endproperty
  a_win_expire: assert property (p_win_expire)
    else $error("command window did not close after four cycles");

  property p_lock_read;
    @(posedge clk_in) disable iff (rst_in)
    (s_r.st == FSP_ARMED && cmd_w == FSP_CMD_LOCK && cpu_req_in.load &&
     !cpu_req_in.store && s_r.win > 3'h1 && !eeprom_write_busy_in &&
     cpu_req_in.z == FSP_Z_LOCK)
    |=> (lpm_hit_out && lpm_data_out == lock_bits_out && !s_r.spm_en);
  endproperty
  a_lock_read: assert property (p_lock_read)
    else $error("lock byte not returned in read window");

  property p_irq;
    @(posedge clk_in) disable iff (rst_in)
    irq_out == (s_r.ie && s_r.st == FSP_IDLE);
  endproperty
  a_irq: assert property (p_irq)
    else $error("ready interrupt does not follow store_enable");

endmodule : fsp_sequencer

// >>> bench/fsp_cpu_model.sv
// cpu core model issuing store-program and load-program instructions
`timescale 1ns/1ns
module fsp_cpu_model
  import fsp_pkg::*;
(
  // clock
  input  logic         clk_in,
  // sequencer answers
  input  logic         lpm_hit_in,
  input  logic [7:0]   lpm_data_in,
  // instruction requests
  output fsp_cpu_req_s cpu_req_out
);
  initial cpu_req_out = '0;

  // operands are inverted on release so a stale pointer never looks valid
  task automatic spm(input logic [15:0] z, input logic [15:0] d);
    @(posedge clk_in);
    cpu_req_out <= {2'b10, z, d};
    @(posedge clk_in);
    cpu_req_out <= {2'b00, ~z, ~d};
    #1;
  endtask : spm

  task automatic lpm(input logic [15:0] z, output logic hit, output logic [7:0] q);
    @(posedge clk_in);
    cpu_req_out <= {2'b01, z, 16'hFFFF};
    @(posedge clk_in);
    cpu_req_out <= {2'b00, ~z, 16'h0000};
    #1;
    hit = lpm_hit_in;
    q   = lpm_data_in;
  endtask : lpm
endmodule : fsp_cpu_model

// >>> bench/tb.sv
// self-checking bench for the flash self-program sequencer
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  import fsp_pkg::*;
  localparam int PW   = 6;
  localparam int PROG = 10;
  logic               clk_in;
  logic               rst_in;
  logic               ee_busy;
  logic               hit;
  logic               lpm_hit;
  logic               halt;
  logic               irq;
  logic               erase;
  logic               pwrite;
  logic               area_busy;
  fsp_reg_req_s       req;
  fsp_cpu_req_s       cpu;
  fsp_fuse_s          fuse;
  logic [PW-1:0]      buf_addr;
  logic [15:0]        buf_data;
  logic [14-PW:0]     page;
  logic [7:0]         rdata;
  logic [7:0]         lpm_data;
  logic [7:0]         lock;
  logic [7:0]         q;
  logic [7:0]         exp_rd [4];
  int                 n;
  int                 n_fail;
  int                 samples_checked;

  fsp_sequencer #(.PAGE_WORD_BITS(PW), .PROG_CYCLES(PROG)) dut_u (
    .clk_in(clk_in), .rst_in(rst_in), .reg_req_in(req), .reg_rdata_out(rdata),
    .cpu_req_in(cpu), .lpm_data_out(lpm_data), .lpm_hit_out(lpm_hit),
    .halt_out(halt), .irq_out(irq), .eeprom_write_busy_in(ee_busy), .fuse_in(fuse),
    .flash_buf_addr_in(buf_addr), .flash_buf_data_out(buf_data),
    .flash_erase_out(erase), .flash_write_out(pwrite), .flash_page_out(page),
    .rww_busy_out(area_busy), .lock_bits_out(lock)
  );

  fsp_cpu_model cpu_u (
    .clk_in(clk_in), .lpm_hit_in(lpm_hit), .lpm_data_in(lpm_data), .cpu_req_out(cpu)
  );

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    req <= '0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    req <= '0;
    #1;
    d = rdata;
  endtask : reg_rd

  task automatic ctrl_is(input logic [7:0] e);
    reg_rd(FSP_CTRL_OFS, q);
    `CHK(q, e)
  endtask : ctrl_is

  task automatic buf_is(input logic [PW-1:0] w, input logic [15:0] e);
    @(posedge clk_in);
    buf_addr <= w;
    repeat (2) @(posedge clk_in);
    #1;
    `CHK(buf_data, e)
  endtask : buf_is

  // polls store_enable; a hang counts as a mismatch
  task automatic wait_idle();
    int i;
    for (i = 0; i < 40; i++) begin
      reg_rd(FSP_CTRL_OFS, q);
      if (q[FSP_SEN_BIT] === 1'b0) break;
    end
    if (i == 40) begin
      n_fail++;
      test_done();
    end
  endtask : wait_idle

  initial begin
    rst_in = 1'b1;
    req = '0;
    ee_busy = 1'b0;
    buf_addr = '0;
    fuse = '{low: 8'h62, high: 8'h99, ext: 8'hFD};
    exp_rd = '{8'h62, 8'hFF, 8'hFD, 8'h99};
    n_fail = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    ctrl_is(8'h00);
    reg_rd(FSP_LOCK_OFS, q);
    `CHK(q, 8'hFF)
    reg_rd(8'h05, q);
    `CHK(q, 8'h00)
    // pointer picks fuse or lock byte in the read window
    for (int z = 0; z < 4; z++) begin
      reg_wr(FSP_CTRL_OFS, 8'h09);
      cpu_u.lpm(16'(z), hit, q);
      `CHK(hit, 1'b1)
      `CHK(q, exp_rd[z])
      ctrl_is(8'h00);
    end
    reg_wr(FSP_CTRL_OFS, 8'h09);
    repeat (2) @(posedge clk_in);
    cpu_u.lpm(FSP_Z_LOCK, hit, q);
    `CHK(hit, 1'b0)
    ctrl_is(8'h00);
    reg_wr(FSP_CTRL_OFS, 8'h89);
    cpu_u.spm(FSP_Z_LOCK, 16'hFFE7);
    `CHK(halt, 1'b0)
    `CHK(irq, 1'b0)
    `CHK(lock, 8'hE7)
    wait_idle();
    `CHK(irq, 1'b1)
    reg_rd(FSP_LOCK_OFS, q);
    `CHK(q, 8'hE7)
    reg_wr(FSP_CTRL_OFS, 8'h87);
    ctrl_is(8'h80);
    reg_wr(FSP_CTRL_OFS, 8'h07);
    ctrl_is(8'h00);
    `CHK(irq, 1'b0)
    reg_wr(FSP_CTRL_OFS, 8'h03);
    repeat (3) @(posedge clk_in);
    cpu_u.spm(16'hF000, 16'h0000);
    `CHK(erase, 1'b0)
    ctrl_is(8'h00);
    reg_wr(FSP_CTRL_OFS, 8'h01);
    cpu_u.spm(16'h018B, 16'h1234);
    buf_is(6'd5, 16'h1234);
    reg_wr(FSP_CTRL_OFS, 8'h05);
    cpu_u.spm(16'h01FF, 16'h5555);
    `CHK(pwrite, 1'b1)
    `CHK(page, 9'h003)
    `CHK(halt, 1'b0)
    `CHK(area_busy, 1'b1)
    ctrl_is(8'h45);
    wait_idle();
    ctrl_is(8'h40);
    buf_is(6'd5, 16'hFFFF);
    reg_wr(FSP_CTRL_OFS, 8'h01);
    cpu_u.spm(16'h0012, 16'hABCD);
    `CHK(area_busy, 1'b0)
    // erase in the halting area; halt length shows the cell timer
    reg_wr(FSP_CTRL_OFS, 8'h03);
    cpu_u.spm(16'hF07F, 16'h0000);
    `CHK(erase, 1'b1)
    `CHK(page, 9'h1E0)
    `CHK(area_busy, 1'b1)
    n = 0;
    while (halt === 1'b1 && n < 100) begin
      n++;
      @(posedge clk_in);
      #1;
    end
    `CHK(n, PROG)
    ctrl_is(8'h40);
    reg_wr(FSP_CTRL_OFS, 8'h11);
    cpu_u.spm(16'h0000, 16'h0000);
    `CHK(area_busy, 1'b0)
    buf_is(6'd9, 16'hFFFF);
    reg_wr(FSP_CTRL_OFS, 8'h01);
    cpu_u.spm(16'h000E, 16'hBEEF);
    buf_is(6'd7, 16'hBEEF);
    // read window opened with the eeprom idle, then an eeprom write starts
    reg_wr(FSP_CTRL_OFS, 8'h09);
    ee_busy <= 1'b1;
    cpu_u.lpm(FSP_Z_LOCK, hit, q);
    `CHK(hit, 1'b0)
    reg_wr(FSP_CTRL_OFS, 8'h09);
    ctrl_is(8'h00);
    @(posedge clk_in);
    ee_busy <= 1'b0;
    buf_is(6'd7, 16'hFFFF);
    reg_wr(FSP_CTRL_OFS, 8'h01);
    cpu_u.spm(16'h0004, 16'h0F0F);
    buf_is(6'd2, 16'h0F0F);
    // a reset in mid-run must also empty the page buffer
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    buf_is(6'd2, 16'hFFFF);
    test_done();
  end
endmodule : tb
